// File: sipo_map.vh
// constants of the serial-in parallel-out latch block
// assumes inclusion by sipo_latch.v only
//
// Function
// - eight shift stages feed eight storage bits
// - storage bits drive eight three-state outputs
// - separate shift clock and storage clock
// - both registers change on rising edges
// - clear overrides clock, serial in, cascade out
// - common clocks: storage lags one pulse
// - enable high forces all eight parallel outputs high-impedance; cascade output stays driven
// - clear low zeroes stages and cascade output
// - shift edge: stage takes previous, first takes input
// - storage edge loads all eight stages
`ifndef SIPO_MAP_VH
`define SIPO_MAP_VH
`define SIPO_WIDTH       8
`define SIPO_FIFO_DEPTH  32
`define SIPO_RESET_VAL   8'h00
`define SIPO_LAST_STAGE  7
`endif

// File: sipo_fifo.v
// small fifo holding captured parallel words
// assumes a single clock and an active low async reset
`timescale 1ns/1ps
module sipo_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             i_core_clk,
    input  wire             i_arst_n,
    input  wire             i_in_valid,
    output wire             o_in_ready,
    input  wire [WIDTH-1:0] i_in_data,
    output reg              o_out_valid,
    input  wire             i_out_ready,
    output reg  [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_q;
    reg [AW:0]      rd_q;
    wire            full;
    wire            empty;
    wire            pop;
    wire            push;

    assign full       = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
    assign empty      = (wr_q == rd_q);
    assign o_in_ready = ~full;
    assign push       = i_in_valid & ~full;
    // read data comes out of a register; refill it whenever it drains
    assign pop        = ~empty & (~o_out_valid | i_out_ready);

    always @(posedge i_core_clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= i_in_data;
        end
    end

    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_q        <= {(AW+1){1'b0}};
            rd_q        <= {(AW+1){1'b0}};
            o_out_valid <= 1'b0;
            o_out_data  <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q        <= rd_q + 1'b1;
                o_out_data  <= mem[rd_q[AW-1:0]];
                o_out_valid <= 1'b1;
            end else if (i_out_ready) begin
                o_out_valid <= 1'b0;
            end
        end
    end
endmodule // sipo_fifo

// File: sipo_latch.v
// serial-in parallel-out shift register with storage latches
// the five serial pins arrive asynchronously and are synchronised to i_core_clk;
// clock pins are edge-detected, so pin clocks must stay well below core/4
`timescale 1ns/1ps
`include "sipo_map.vh"
module sipo_latch #(
    parameter WIDTH = `SIPO_WIDTH,
    parameter DEPTH = `SIPO_FIFO_DEPTH
) (
    input  wire             i_core_clk,
    input  wire             i_arst_n,
    input  wire             i_shift_data_in,
    input  wire             i_shift_clock,
    input  wire             i_storage_clock,
    input  wire             i_shift_clear_n,
    input  wire             i_output_enable_n,
    output reg  [WIDTH-1:0] o_parallel_out,
    output reg  [WIDTH-1:0] o_parallel_oe,
    output reg              o_serial_out,
    output reg              o_word_valid,
    input  wire             i_word_ready,
    output reg  [WIDTH-1:0] o_word_data,
    output reg              o_word_overrun
);
    // ******************************
    // pin synchronisers
    // ******************************
    reg  [4:0] sync1_q;
    reg  [4:0] sync2_q;
    reg        sck_prev_q;
    reg        rck_prev_q;
    wire       ser_s;
    wire       sck_s;
    wire       rck_s;
    wire       clr_n_s;
    wire       oe_n_s;
    wire       sck_rise;
    wire       rck_rise;

    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync1_q    <= 5'h00;
            sync2_q    <= 5'h00;
            sck_prev_q <= 1'b0;
            rck_prev_q <= 1'b0;
        end else begin
            sync1_q    <= {i_output_enable_n, i_shift_clear_n, i_storage_clock,
                           i_shift_clock, i_shift_data_in};
            sync2_q    <= sync1_q;
            sck_prev_q <= sync2_q[1];
            rck_prev_q <= sync2_q[2];
        end
    end

    assign ser_s    = sync2_q[0];
    assign sck_s    = sync2_q[1];
    assign rck_s    = sync2_q[2];
    assign clr_n_s  = sync2_q[3];
    assign oe_n_s   = sync2_q[4];
    // rising edge of a synchronised pin level against its previous sample
    function rise_of;
        input level;
        input prev;
        begin
            rise_of = level & ~prev;
        end
    endfunction

    assign sck_rise = rise_of(sck_s, sck_prev_q);
    assign rck_rise = rise_of(rck_s, rck_prev_q);

    // ******************************
    // shift and storage registers
    // ******************************
    reg  [WIDTH-1:0] shift_q;
    reg  [WIDTH-1:0] store_q;
    wire [WIDTH-1:0] shift_d;

    // stage 0 takes serial input, each later stage its predecessor
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_stage
            if (g == 0) begin : g_first
                assign shift_d[g] = ser_s;
            end else begin : g_next
                assign shift_d[g] = shift_q[g-1];
            end
        end
    endgenerate

    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            shift_q <= `SIPO_RESET_VAL;
        end else if (!clr_n_s) begin
            shift_q <= {WIDTH{1'b0}};
        end else if (sck_rise) begin
            shift_q <= shift_d;
        end
    end

    // storage samples the pre-edge stages, so a shared clock lags by one pulse
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            store_q <= `SIPO_RESET_VAL;
        end else if (rck_rise) begin
            store_q <= shift_q;
        end
    end

    // ******************************
    // pin outputs
    // ******************************
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_parallel_out <= `SIPO_RESET_VAL;
            o_parallel_oe  <= {WIDTH{1'b0}};
            o_serial_out   <= 1'b0;
        end else begin
            o_parallel_out <= store_q;
            o_parallel_oe  <= {WIDTH{~oe_n_s}};
            // clear zeroes the cascade bit in the same cycle as the stages
            o_serial_out   <= clr_n_s ? shift_q[WIDTH-1] : 1'b0;
        end
    end

    // ******************************
    // capture fifo of stored words
    // ******************************
    wire            fifo_ready;
    wire            fifo_valid;
    wire [WIDTH-1:0] fifo_data;
    reg             push_q;

    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            push_q         <= 1'b0;
            o_word_overrun <= 1'b0;
        end else begin
            push_q <= rck_rise;
            // a word lost to a full fifo is flagged until reset
            if (push_q && !fifo_ready) begin
                o_word_overrun <= 1'b1;
            end
        end
    end

    sipo_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH),
        .AW    ($clog2(DEPTH))
    ) u_fifo (
        .i_core_clk  (i_core_clk),
        .i_arst_n    (i_arst_n),
        .i_in_valid  (push_q),
        .o_in_ready  (fifo_ready),
        .i_in_data   (store_q),
        .o_out_valid (fifo_valid),
        .i_out_ready (i_word_ready | ~o_word_valid),
        .o_out_data  (fifo_data)
    );

    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_word_valid <= 1'b0;
            o_word_data  <= `SIPO_RESET_VAL;
        end else if (i_word_ready || !o_word_valid) begin
            o_word_valid <= fifo_valid;
            o_word_data  <= fifo_data;
        end
    end
endmodule // sipo_latch

// File: sipo_checker.sv
// sipo checker: timing relations seen at the block pins
// assumes one core clock and an async active-low reset
`timescale 1ns/1ps
module sipo_checker #(parameter WIDTH = 8) (
    input wire logic             i_core_clk,
    input wire logic             i_arst_n,
    input wire logic             i_shift_clock,
    input wire logic             i_storage_clock,
    input wire logic             i_shift_clear_n,
    input wire logic             i_output_enable_n,
    input wire logic             i_word_ready,
    input wire logic [WIDTH-1:0] o_parallel_out,
    input wire logic [WIDTH-1:0] o_parallel_oe,
    input wire logic             o_serial_out,
    input wire logic             o_word_valid,
    input wire logic [WIDTH-1:0] o_word_data,
    input wire logic             o_word_overrun
);
// ****
// properties
// ****
default clocking cb @(posedge i_core_clk); endclocking
default disable iff (!i_arst_n);
oe_off_a: assert property (i_output_enable_n [*6] |-> o_parallel_oe == '0)
    else $error("outputs driven while disabled");
oe_on_a: assert property (!i_output_enable_n [*6] |-> o_parallel_oe == '1)
    else $error("outputs not driven while enabled");
oe_whole_a: assert property (o_parallel_oe == '0 || o_parallel_oe == '1)
    else $error("enables split");
clear_zero_a: assert property (!i_shift_clear_n [*6] |-> !o_serial_out)
    else $error("cascade not zero under clear");
shift_idle_a: assert property ((i_shift_clear_n && !i_shift_clock) [*8]
    |-> $stable(o_serial_out)) else $error("cascade moved without edge");
store_idle_a: assert property (!i_storage_clock [*8] |-> $stable(o_parallel_out))
    else $error("storage moved without edge");
store_word_a: assert property ($rose(i_storage_clock) |-> ##[1:10] o_word_valid)
    else $error("no word after storage edge");
word_hold_a: assert property (o_word_valid && !i_word_ready
    |=> o_word_valid && $stable(o_word_data)) else $error("word dropped");
cover property ($rose(o_word_overrun));
cover property (o_word_valid && i_word_ready);
cover property ($fell(i_shift_clear_n));
endmodule // sipo_checker
bind sipo_latch sipo_checker #(.WIDTH(WIDTH)) u_sipo_checker (.*);

// File: sipo_host.sv
// sipo host: controller driving the serial pins
// assumes pins are sampled by a core clock; levels held 4 cycles
`timescale 1ns/1ps
module sipo_host (
    input  wire logic i_core_clk,
    output logic      o_shift_data_in,
    output logic      o_shift_clock,
    output logic      o_storage_clock,
    output logic      o_shift_clear_n,
    output logic      o_output_enable_n
);
// ****
// pin sequencing
// ****
initial begin
    o_shift_data_in = 1'b0;
    o_shift_clock = 1'b0;
    o_storage_clock = 1'b0;
    o_shift_clear_n = 1'b1;
    o_output_enable_n = 1'b1;
end
// shorter levels could be missed by the pin synchronisers
task automatic hold();
    repeat (4) @(posedge i_core_clk);
    #2;
endtask
// msb first, so bit 0 ends in the first stage
task automatic send(input logic [7:0] b, input logic both);
    for (int i = 7; i >= 0; i--) begin
        o_shift_data_in = b[i];
        hold();
        o_shift_clock = 1'b1;
        o_storage_clock = both; // shared clock when set
        hold();
        o_shift_clock = 1'b0;
        o_storage_clock = 1'b0;
    end
endtask
task automatic store();
    o_storage_clock = 1'b1;
    hold();
    o_storage_clock = 1'b0;
    hold();
endtask
task automatic pins(input logic clr_n, input logic oe_n);
    o_shift_clear_n = clr_n;
    o_output_enable_n = oe_n;
    hold();
endtask
endmodule // sipo_host

// File: testbench.sv
// testbench: random bytes through the shift, store and word paths
// assumes sipo_host drives the pins and the checker is bound
`timescale 1ns/1ps
module testbench;
// ****
// signals
// ****
logic       i_core_clk = 1'b0;
logic       i_arst_n = 1'b0;
logic       i_word_ready = 1'b0;
logic       stall = 1'b0;
wire        sdi, sck, storage_clock, clr_n, oe_n, sout, wvalid, ovr;
wire  [7:0] pout, poe, wdata;
logic [7:0] exp_q[$];
logic [7:0] b;
int         n_fail = 0;
int         cmp_count = 0;
always #12.5 i_core_clk = ~i_core_clk;
sipo_host u_sipo_host (.i_core_clk(i_core_clk), .o_shift_data_in(sdi), .o_shift_clock(sck),
    .o_storage_clock(storage_clock), .o_shift_clear_n(clr_n), .o_output_enable_n(oe_n));
sipo_latch u_sipo_latch (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_shift_data_in(sdi),
    .i_shift_clock(sck), .i_storage_clock(storage_clock), .i_shift_clear_n(clr_n),
    .i_output_enable_n(oe_n), .o_parallel_out(pout), .o_parallel_oe(poe), .o_serial_out(sout),
    .o_word_valid(wvalid), .i_word_ready(i_word_ready), .o_word_data(wdata),
    .o_word_overrun(ovr));
// ****
// tasks and watchers
// ****
task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
        n_fail++;
        $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
endtask
task automatic settle();
    repeat (8) @(posedge i_core_clk);
    #2;
endtask
task automatic drain();
    for (int i = 0; i < 3000 && exp_q.size() > 0; i++) @(posedge i_core_clk);
    check("left", 8'(exp_q.size()), 8'h00);
    #2;
endtask
task automatic finish_test();
    if (n_fail == 0 && cmp_count > 0) begin
        $display("All checks passed");
    end else begin
        $display("Checks failed");
    end
    $finish;
endtask
always @(posedge i_core_clk) begin
    #2;
    i_word_ready = !stall && $urandom_range(0, 1) == 1;
end
always @(posedge i_core_clk) begin
    if (wvalid === 1'b1 && i_word_ready === 1'b1) begin
        check("word", wdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    end
end
initial begin
    repeat (20000) @(posedge i_core_clk);
    n_fail++;
    finish_test();
end
// ****
// main sequence
// ****
initial begin
    void'($urandom(32'hb088_8bb5));
    repeat (20) @(posedge i_core_clk);
    #2;
    i_arst_n = 1'b1;
    settle();
    check("oe", poe, 8'h00);
    for (int k = 0; k < 4; k++) begin
        b = 8'($urandom);
        u_sipo_host.send(b, 1'b0);
        settle();
        check("cascade", {7'h00, sout}, {7'h00, b[7]});
        exp_q.push_back(b);
        u_sipo_host.store();
        settle();
        check("parallel", pout, b);
    end
    u_sipo_host.pins(1'b1, 1'b0);
    settle();
    check("oe", poe, 8'hff);
    u_sipo_host.pins(1'b0, 1'b0);
    settle();
    check("cleared", {7'h00, sout}, 8'h00);
    check("kept", pout, b);
    u_sipo_host.pins(1'b1, 1'b0);
    exp_q.push_back(8'h00);
    u_sipo_host.store();
    settle();
    check("zeroed", pout, 8'h00);
    b = 8'($urandom);
    for (int k = 1; k <= 8; k++) exp_q.push_back(b >> (9 - k));
    u_sipo_host.send(b, 1'b1);
    settle();
    check("lag", pout, b >> 1);
    drain();
    stall = 1'b1;
    // one word in the output register, one in the fifo read register and
    // 32 in the fifo memory: the 35th store is the first one dropped
    repeat (35) u_sipo_host.store();
    repeat (34) exp_q.push_back(b);
    settle();
    check("overrun", {7'h00, ovr}, 8'h01);
    stall = 1'b0;
    drain();
    finish_test();
end
endmodule // testbench
